// [hw/cod_pkg.sv]
/*
  Constants and types for the configuration byte option decoder.
  Assumes one 40 MHz clock domain and eight-bit configuration bytes.
*/
package cod_pkg;
  // Byte width and working-copy selectors
  localparam int         BYTE_W   = 8;
  localparam logic [1:0] IDX_BOOT = 2'h0;
  localparam logic [1:0] IDX_BOD  = 2'h1;
  localparam logic [1:0] IDX_WDT  = 2'h2;
  // Reset values of the working copies (erased state)
  localparam logic [7:0] BOOT_RST = 8'hFF;
  localparam logic [7:0] BOD_RST  = 8'hFF;
  localparam logic [7:0] WDT_RST  = 8'hFF;
  // Reserved bits, forced to the unprogrammed level
  localparam logic [7:0] BOOT_RSV = 8'hF8;
  localparam logic [7:0] BOD_RSV  = 8'h43;
  localparam logic [7:0] WDT_RSV  = 8'h0F;
  // Field positions
  localparam int BOOT_LSB    = 0;
  localparam int BOD_ON_BIT  = 7;
  localparam int BOD_LVL_LSB = 4;
  localparam int BOD_IAP_BIT = 3;
  localparam int BOD_RST_BIT = 2;
  localparam int WDT_LSB     = 4;
  // Field codes
  localparam logic [2:0] BOOT_NONE = 3'h7;
  localparam logic [3:0] WDT_OFF   = 4'hF;
  localparam logic [3:0] WDT_HALT  = 4'h5;
  // Flash split in kilobytes
  localparam logic [4:0] FLASH_KB  = 5'h12;
  localparam logic [2:0] BOOT_MAX  = 3'h4;
  // Serial programming frame
  localparam logic [4:0] HDR_BITS   = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int         HDR_RD_BIT = 7;

  // Loader states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LOAD  = 2'b01,
    ST_RUN   = 2'b10,
    ST_PROG  = 2'b11
  } cod_state_type;

  // Brown-out trip levels
  typedef enum logic [1:0] {
    LVL_4V4 = 2'b00,
    LVL_3V7 = 2'b01,
    LVL_2V7 = 2'b10,
    LVL_2V2 = 2'b11
  } cod_level_type;

  // Watchdog behaviour
  typedef enum logic [1:0] {
    WDM_TIMER = 2'b00,
    WDM_RUN   = 2'b01,
    WDM_HALT  = 2'b10
  } cod_wdt_mode_type;
endpackage

// [hw/cod_option_decode.sv]
/*
  Combinational decode of the three working configuration bytes.
  Assumes the caller registers every output before it leaves the block.
*/
`timescale 1ns/1ps
module cod_option_decode (
  // Working copies
  input  wire logic [7:0]               boot_byte,
  input  wire logic [7:0]               bod_byte,
  input  wire logic [7:0]               wdt_byte,
  // Synchronised supply comparator
  input  wire logic                     bod_low,
  // Brown-out level and flash split
  output cod_pkg::cod_level_type        bod_level,
  output logic [2:0]                    boot_kb,
  output logic [4:0]                    app_kb,
  // Brown-out options
  output logic                          bod_on,
  output logic                          selfprog_inhibit,
  output logic                          bod_reset_req,
  // Watchdog
  output cod_pkg::cod_wdt_mode_type     wdt_mode
);
  import cod_pkg::*;

  logic [2:0] size_code; // Boot block size field
  logic [3:0] wdt_code;  // Watchdog enable field

  // Decode all options from the working bytes
  always_comb begin
    size_code = boot_byte[BOOT_LSB +: 3];
    wdt_code  = wdt_byte[WDT_LSB +: 4];
    // Any 0xx code lands on the largest boot block
    if (size_code[2] == 1'b0) begin
      boot_kb = BOOT_MAX;
    end else begin
      boot_kb = BOOT_NONE - size_code;
    end
    app_kb = FLASH_KB - {2'b00, boot_kb};
    bod_on = bod_byte[BOD_ON_BIT];
    bod_level = cod_level_type'(bod_byte[BOD_LVL_LSB +: 2]);
    // Inhibit only counts while detection is running
    selfprog_inhibit = bod_on & bod_byte[BOD_IAP_BIT] & bod_low;
    bod_reset_req = bod_on & bod_byte[BOD_RST_BIT] & bod_low;
    if (wdt_code == WDT_OFF) begin
      wdt_mode = WDM_TIMER;
    end else if (wdt_code == WDT_HALT) begin
      wdt_mode = WDM_HALT;
    end else begin
      wdt_mode = WDM_RUN;
    end
  end
endmodule

// [hw/cod_prog_shift.sv]
/*
  Serial programming shifter: 16-bit frames, MSB first, sampled on the
  rising edge of the synchronised programming clock.
  Assumes clock and data inputs are already synchronised to mclk.
*/
`timescale 1ns/1ps
module cod_prog_shift (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Mode and synchronised pins
  input  wire logic       active,
  input  wire logic       pclk_s,
  input  wire logic       pdat_s,
  // Storage read data for the addressed byte
  input  wire logic [7:0] rd_data,
  // Addressed byte and write strobe
  output logic [1:0]      idx,
  output logic [7:0]      wr_data,
  output logic            wr_pulse,
  // Serial data out
  output logic            dout,
  output logic            doe_n
);
  import cod_pkg::*;

  typedef struct packed {
    logic       pclk_prev;
    logic [4:0] cnt;
    logic [7:0] hdr;
    logic [7:0] dat;
    logic [7:0] rsh;
    logic       wr;
    logic       dout;
    logic       doe_n;
  } cod_shift_type;

  cod_shift_type s_q;
  cod_shift_type s_d;

  // Shift on clock edges; frames restart whenever the mode drops
  always_comb begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.pclk_prev = pclk_s;
    if (rst || !active) begin
      s_d = '0;
      s_d.doe_n = 1'b1;
    end else if (pclk_s && !s_q.pclk_prev) begin
      if (s_q.cnt < HDR_BITS) begin
        s_d.hdr = {s_q.hdr[6:0], pdat_s};
      end else begin
        s_d.dat = {s_q.dat[6:0], pdat_s};
        s_d.rsh = {s_q.rsh[6:0], 1'b0};
      end
      if (s_q.cnt == FRAME_BITS - 5'h01) begin
        s_d.cnt = '0;
        s_d.wr = ~s_q.hdr[HDR_RD_BIT];
      end else begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end else if (!pclk_s && s_q.pclk_prev) begin
      // Drive on falling edges so the programmer samples a settled bit
      s_d.doe_n = ~(s_q.hdr[HDR_RD_BIT] && s_q.cnt >= HDR_BITS);
      // The index is whole only once the header is in
      if (s_q.cnt == HDR_BITS) begin
        s_d.rsh = rd_data;
      end
      s_d.dout = s_d.rsh[7];
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  assign idx = s_q.hdr[1:0];
  assign wr_data = s_q.dat;
  assign wr_pulse = s_q.wr;
  assign dout = s_q.dout;
  assign doe_n = s_q.doe_n;
endmodule

// [hw/cod_top.sv]
/*
  Configuration byte option decoder: holds working copies of the boot
  size, brown-out and watchdog configuration bytes, reloads them after
  resets, decodes them into registered option signals and serves the
  three-pin serial programming port that writes the stored bytes.
  Assumes the non-volatile storage presents its bytes combinationally
  on mclk, and that por is high during rst after a power-on.
  Brown-out copy survives warm resets;
  the processor waits until options settle.
*/
`timescale 1ns/1ps
module cod_top (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    por,
  // Non-volatile storage contents
  input  wire logic [7:0]              nv_boot_byte,
  input  wire logic [7:0]              nv_bod_byte,
  input  wire logic [7:0]              nv_wdt_byte,
  // Non-volatile storage write port
  output logic                         nv_wr,
  output logic [1:0]                   nv_wr_idx,
  output logic [7:0]                   nv_wr_data,
  // Software access to the working copies
  input  wire logic                    sfr_wr,
  input  wire logic [1:0]              sfr_idx,
  input  wire logic [7:0]              sfr_wdata,
  output logic [7:0]                   sfr_rdata,
  // Serial programming pins
  input  wire logic                    rst_n_pin,
  input  wire logic                    prog_clock_pin,
  input  wire logic                    prog_data_in,
  output logic                         prog_data_out,
  output logic                         prog_data_oe_n,
  // Analog supply comparator
  input  wire logic                    brownout_low_pin,
  // Flash split
  output logic [2:0]                   boot_block_size,
  output logic [2:0]                   boot_flash_kb,
  output logic [4:0]                   application_flash_kb,
  // Brown-out options
  output logic                         brownout_detect_on,
  output cod_pkg::cod_level_type       brownout_trip_level,
  output logic                         brownout_blocks_selfprog,
  output logic                         brownout_reset_req,
  // Watchdog options
  output cod_pkg::cod_wdt_mode_type    watchdog_mode,
  // Status
  output logic                         cpu_hold,
  output logic                         prog_mode,
  output logic                         options_valid
);
  import cod_pkg::*;

  // State of the block, apart from the shifter's own register
  typedef struct packed {
    cod_state_type    state;
    logic             settled;   // Options caught up with copies
    logic             por_seen;
    logic [7:0]       boot_byte;
    logic [7:0]       bod_byte;
    logic [7:0]       wdt_byte;
    logic [1:0]       rstn_sync;
    logic [1:0]       pclk_sync;
    logic [1:0]       pdat_sync;
    logic [1:0]       bod_sync;
    logic [2:0]       boot_kb;
    logic [4:0]       app_kb;
    logic             bod_on;
    cod_level_type    bod_level;
    logic             sp_inhibit;
    logic             bod_rst;
    cod_wdt_mode_type wdt_mode;
    logic [7:0]       rdata;
  } cod_top_type;

  // All state outside the shifter in one register
  cod_top_type r_q;          // Registered state
  cod_top_type r_d;          // Next state

  // Decode results, registered below
  logic [2:0]       dec_boot_kb;   // Decoder outputs
  logic [4:0]       dec_app_kb;
  logic             dec_bod_on;
  cod_level_type    dec_level;
  logic             dec_inhibit;
  logic             dec_bod_rst;
  cod_wdt_mode_type dec_wdt;

  // Shifter side of the block
  logic [1:0]       ps_idx;        // Programming shifter outputs
  logic [7:0]       ps_wdata;
  logic             ps_wr;
  logic             ps_dout;
  logic             ps_doe_n;
  logic [7:0]       ps_rdata;      // Stored byte for the addressed index

  // Force reserved bits to the unprogrammed level so a careless write
  // can never turn them into live option bits
  // A plain OR, so no added depth
  function automatic logic [7:0] keep_rsv(input logic [7:0] b,
                                          input logic [7:0] m);
    keep_rsv = b | m;
  endfunction

  // Pick one of three bytes by index; unused index reads all ones
  // Shared by readback and the shifter
  function automatic logic [7:0] pick(input logic [1:0] i,
                                      input logic [7:0] b0,
                                      input logic [7:0] b1,
                                      input logic [7:0] b2);
    case (i)
      IDX_BOOT: pick = b0;
      IDX_BOD:  pick = b1;
      IDX_WDT:  pick = b2;
      default:  pick = 8'hFF;
    endcase
  endfunction

  // Stored byte returned to the programmer
  // Raw, so reserved bits read as stored
  assign ps_rdata = pick(ps_idx, nv_boot_byte, nv_bod_byte, nv_wdt_byte);

  // Option decode from the working copies
  // It never reads storage directly
  cod_option_decode u_dec (
    .boot_byte        (r_q.boot_byte),
    .bod_byte         (r_q.bod_byte),
    .wdt_byte         (r_q.wdt_byte),
    .bod_low          (r_q.bod_sync[1]),
    .bod_level        (dec_level),
    .boot_kb          (dec_boot_kb),
    .app_kb           (dec_app_kb),
    .bod_on           (dec_bod_on),
    .selfprog_inhibit (dec_inhibit),
    .bod_reset_req    (dec_bod_rst),
    .wdt_mode         (dec_wdt)
  );

  // Serial programming shifter, live only in programming mode
  // Leaving the mode drops a cut frame
  cod_prog_shift u_shift (
    .mclk     (mclk),
    .rst      (rst),
    .active   (r_q.state == ST_PROG),
    .pclk_s   (r_q.pclk_sync[1]),
    .pdat_s   (r_q.pdat_sync[1]),
    .rd_data  (ps_rdata),
    .idx      (ps_idx),
    .wr_data  (ps_wdata),
    .wr_pulse (ps_wr),
    .dout     (ps_dout),
    .doe_n    (ps_doe_n)
  );

  // Next-state logic: synchronisers, loader, software writes, decode
  always_comb begin
    r_d = r_q;
    // Fields hold unless set below
    // Two-flop synchronisers; only stage 1 reads stage 0
    r_d.rstn_sync = {r_q.rstn_sync[0], rst_n_pin};
    r_d.pclk_sync = {r_q.pclk_sync[0], prog_clock_pin};
    r_d.pdat_sync = {r_q.pdat_sync[0], prog_data_in};
    r_d.bod_sync  = {r_q.bod_sync[0], brownout_low_pin};
    if (rst) begin
      // Boot and watchdog copies return to the erased state
      r_d.state     = ST_RESET;
      r_d.por_seen  = por;
      r_d.boot_byte = BOOT_RST;
      r_d.wdt_byte  = WDT_RST;
      // Brown-out copy survives warm resets, reset only at power-on
      // so a brown-out reset keeps its level
      if (por) begin
        r_d.bod_byte = BOD_RST;
      end
      // Sync chains idle at the inactive pin levels
      r_d.rstn_sync = 2'b11;
      r_d.pclk_sync = 2'b00;
      r_d.pdat_sync = 2'b00;
      r_d.bod_sync  = 2'b00;
      r_d.rdata     = 8'h00;
    end else begin
      case (r_q.state)
        // Wait one cycle so the storage outputs have settled
        // Storage may move during rst
        ST_RESET: begin
          r_d.state = ST_LOAD;
        end
        // Copy stored bytes into the working copies
        ST_LOAD: begin
          r_d.boot_byte = keep_rsv(nv_boot_byte, BOOT_RSV);
          r_d.wdt_byte  = keep_rsv(nv_wdt_byte, WDT_RSV);
          if (r_q.por_seen) begin
            r_d.bod_byte = keep_rsv(nv_bod_byte, BOD_RSV);
          end
          r_d.por_seen = 1'b0;
          // Decode lags the copies by one edge
          r_d.settled = 1'b0;
          r_d.state = ST_RUN;
        end
        // Normal operation; software may change the copies
        ST_RUN: begin
          // One run cycle lets decode catch up
          r_d.settled = 1'b1;
          if (sfr_wr) begin
            case (sfr_idx)
              IDX_BOOT: r_d.boot_byte = keep_rsv(sfr_wdata, BOOT_RSV);
              IDX_BOD:  r_d.bod_byte  = keep_rsv(sfr_wdata, BOD_RSV);
              IDX_WDT:  r_d.wdt_byte  = keep_rsv(sfr_wdata, WDT_RSV);
              default:  r_d.rdata     = r_q.rdata;
            endcase
          end
          // Pin low hands over to the programmer
          if (!r_q.rstn_sync[1]) begin
            r_d.state = ST_PROG;
          end
        end
        // Programming mode: processor held, exit reloads the boot and watchdog copies
        // Storage may have changed meanwhile
        ST_PROG: begin
          if (r_q.rstn_sync[1]) begin
            r_d.state = ST_RESET;
          end
        end
        default: begin
          // Unknown code: start a clean load
          r_d.state = ST_RESET;
        end
      endcase
    end
    // Readback of the working copies
    // One cycle late, like any register
    r_d.rdata = pick(sfr_idx, r_q.boot_byte, r_q.bod_byte, r_q.wdt_byte);
    // Register decoded options; they move only when a copy or the synchronised supply flag changes
    // Registering hides decode glitches
    r_d.boot_kb    = dec_boot_kb;
    r_d.app_kb     = dec_app_kb;
    r_d.bod_on     = dec_bod_on;
    r_d.bod_level  = dec_level;
    r_d.sp_inhibit = dec_inhibit;
    r_d.bod_rst    = dec_bod_rst;
    r_d.wdt_mode   = dec_wdt;
    // Readback clears in reset
    if (rst) begin
      r_d.rdata = 8'h00;
    end
  end

  // State register
  // rst is folded into the next state
  always_ff @(posedge mclk) begin
    r_q <= r_d;
  end

  // Storage writes come only from the programming port
  // Software edits the working copies only
  assign nv_wr      = ps_wr;
  assign nv_wr_idx  = ps_idx;
  assign nv_wr_data = ps_wdata;

  // Programming data pin drive
  // Enable is low while the device drives
  assign prog_data_out  = ps_dout;
  assign prog_data_oe_n = ps_doe_n;

  // Register outputs
  // Size field passes through raw
  assign sfr_rdata                = r_q.rdata;
  assign boot_block_size          = r_q.boot_byte[BOOT_LSB +: 3];
  assign boot_flash_kb            = r_q.boot_kb;
  assign application_flash_kb     = r_q.app_kb;
  assign brownout_detect_on       = r_q.bod_on;
  assign brownout_trip_level      = r_q.bod_level;
  assign brownout_blocks_selfprog = r_q.sp_inhibit;
  assign brownout_reset_req       = r_q.bod_rst;
  assign watchdog_mode            = r_q.wdt_mode;

  // Processor stays held until the decoded options have settled
  // Valid once the outputs show the loaded bytes
  assign options_valid = (r_q.state == ST_RUN) && r_q.settled;
  // Also held throughout programming
  assign cpu_hold      = ~options_valid;
  assign prog_mode     = (r_q.state == ST_PROG);
endmodule

// [tb/cod_top_chk.sv]
/*
  Port checker for cod_top, bound into every instance of it.
  Assumes one mclk domain with a synchronous active-high rst.
*/
`timescale 1ns/1ps
module cod_top_chk (
  // Clock and reset
  input wire logic                      mclk,
  input wire logic                      rst,
  // Inputs seen
  input wire logic                      rst_n_pin,
  input wire logic                      sfr_wr,
  // Outputs watched
  input wire logic                      nv_wr,
  input wire logic                      prog_data_oe_n,
  input wire logic [2:0]                boot_flash_kb,
  input wire logic [4:0]                application_flash_kb,
  input wire logic                      brownout_detect_on,
  input wire cod_pkg::cod_level_type    brownout_trip_level,
  input wire logic                      brownout_blocks_selfprog,
  input wire cod_pkg::cod_wdt_mode_type watchdog_mode,
  input wire logic                      cpu_hold,
  input wire logic                      prog_mode,
  input wire logic                      options_valid
);
  import cod_pkg::*;
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Boot and application parts always make up the whole flash
  a_split_sum: assert property (options_valid && $past(options_valid) |->
    {2'h0, boot_flash_kb} + application_flash_kb == FLASH_KB) else $error("flash split wrong");
  // Release: held, then load and settle, then valid three edges later
  a_release_seq: assert property ($fell(rst) |-> cpu_hold && !options_valid
    ##1 !options_valid [*2] ##1 options_valid && !cpu_hold) else $error("bad release sequence");
  // Self-programming is never blocked while detection is off
  a_block_gate: assert property (brownout_blocks_selfprog |-> brownout_detect_on)
    else $error("block without detection");
  // Device never drives the data wire while running
  a_run_quiet: assert property (options_valid |-> prog_data_oe_n)
    else $error("data wire driven in run");
  // Single-cycle strobe, only in programming mode
  a_wr_pulse: assert property (nv_wr |=> !nv_wr)
    else $error("write strobe too long");
  a_wr_prog: assert property (nv_wr |-> prog_mode)
    else $error("write outside programming");
  // Low reset pin reaches programming within the sync delay
  a_prog_enter: assert property (options_valid && !rst_n_pin |-> ##[1:4] prog_mode)
    else $error("programming not entered");
  // Options hold still unless software wrote two cycles before
  a_opt_stable: assert property (options_valid && $past(options_valid, 2)
    && !$past(sfr_wr, 2) |-> $stable(brownout_trip_level) && $stable(watchdog_mode)
    && $stable(boot_flash_kb) && $stable(brownout_detect_on)) else $error("options moved");
  // Main scenarios reached
  c_prog_write: cover property (prog_mode && nv_wr);
  c_serial_read: cover property (!prog_data_oe_n);
  c_block: cover property (brownout_blocks_selfprog);
endmodule

bind cod_top cod_top_chk u_chk (.mclk, .rst, .rst_n_pin, .sfr_wr, .nv_wr, .prog_data_oe_n,
  .boot_flash_kb, .application_flash_kb, .brownout_detect_on, .brownout_trip_level,
  .brownout_blocks_selfprog, .watchdog_mode, .cpu_hold, .prog_mode, .options_valid);

// [tb/cod_prog_model.sv]
/*
  Far side: configuration storage plus a serial programmer that owns
  the reset pin, the programming clock and the shared data wire.
  Assumes the device drives the wire while its enable is low.
*/
`timescale 1ns/1ps
module cod_prog_model #(
  parameter int HALF = 5 // Programmer half period in mclk cycles
) (
  // Clock
  input  wire logic       mclk,
  // Storage write port
  input  wire logic       nv_wr,
  input  wire logic [1:0] nv_wr_idx,
  input  wire logic [7:0] nv_wr_data,
  // Storage contents
  output logic [7:0]      nv_boot_byte,
  output logic [7:0]      nv_bod_byte,
  output logic [7:0]      nv_wdt_byte,
  // Programming pins
  output logic            rst_n_pin,
  output logic            prog_clock_pin,
  output logic            prog_data_in,
  input  wire logic       prog_data_out,
  input  wire logic       prog_data_oe_n
);
  logic [7:0] mem [3] = '{8'hFF, 8'hFF, 8'hFF}; // Blank parts ship erased
  logic       drv_en  = 1'b0;                   // Programmer owns the wire
  logic       drv_bit = 1'b1;                   // Bit it drives
  logic       last_q  = 1'b1;                   // Last wire level
  initial begin
    rst_n_pin = 1'b1;
    prog_clock_pin = 1'b0; // Clock stands low outside frames
  end
  // Storage takes the strobe; index 3 is not a byte
  always @(posedge mclk) begin
    last_q <= (prog_data_in === 1'b1);
    if (nv_wr && nv_wr_idx != 2'h3) begin
      mem[nv_wr_idx] <= nv_wr_data;
    end
  end
  assign nv_boot_byte = mem[0];
  assign nv_bod_byte  = mem[1];
  assign nv_wdt_byte  = mem[2];
  // Released wire shows a moving level so stale data cannot pass
  assign prog_data_in = !prog_data_oe_n ? prog_data_out : (drv_en ? drv_bit : ~last_q);
  // Reset pin moves the part into and out of programming
  task automatic enter();
    @(negedge mclk);
    rst_n_pin = 1'b0;
    repeat (6) @(negedge mclk);
  endtask
  task automatic leave();
    @(negedge mclk);
    rst_n_pin = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  // Sixteen clocks, MSB first; data read back just before each of the last eight rises
  task automatic frame(input logic [7:0] hdr, input logic [7:0] dat, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {hdr, dat};
    rd = 8'h00;
    for (int i = 0; i < 16; i++) begin
      @(negedge mclk);
      drv_en = (i < 8) || !hdr[7];
      drv_bit = sh[15 - i];
      repeat (HALF) @(negedge mclk);
      if (i >= 8) begin
        rd[15 - i] = prog_data_in;
      end
      prog_clock_pin = 1'b1;
      repeat (HALF) @(negedge mclk);
      prog_clock_pin = 1'b0;
    end
    drv_en = 1'b0;
    repeat (3 * HALF) @(negedge mclk);
  endtask
endmodule

// [tb/tb_cod_top.sv]
/*
  Self-checking bench for cod_top: register-port decode sweeps,
  reset reloads and serial programming through the far-side model.
  Assumes inputs change on the falling edge of mclk.
*/
`timescale 1ns/1ps
module tb_cod_top;
  import cod_pkg::*;
  // Bench-driven inputs
  logic             mclk = 1'b0;
  logic             rst = 1'b1;
  logic             por = 1'b1;
  logic             sfr_wr = 1'b0;
  logic [1:0]       sfr_idx = 2'h0;
  logic [7:0]       sfr_wdata = 8'h00;
  logic             brownout_low_pin = 1'b0;
  // Storage, pins and decoded outputs
  logic [7:0]       nv_boot_byte, nv_bod_byte, nv_wdt_byte, nv_wr_data, sfr_rdata;
  logic [1:0]       nv_wr_idx;
  logic [2:0]       boot_block_size, boot_flash_kb;
  logic [4:0]       application_flash_kb;
  logic             nv_wr, rst_n_pin, prog_clock_pin, prog_data_in, prog_data_out;
  logic             prog_data_oe_n, brownout_detect_on, brownout_blocks_selfprog;
  logic             brownout_reset_req, cpu_hold, prog_mode, options_valid;
  cod_level_type    brownout_trip_level;
  cod_wdt_mode_type watchdog_mode;
  // Tables and counters
  logic [7:0]       bt [4] = '{8'hCF, 8'h4F, 8'hC7, 8'hCB};
  cod_level_type    lv [4] = '{LVL_4V4, LVL_3V7, LVL_2V7, LVL_2V2};
  int               fails = 0;
  int               tests_run = 0;
  int               cycles = 0;

  cod_top dut (.mclk, .rst, .por, .nv_boot_byte, .nv_bod_byte, .nv_wdt_byte, .nv_wr,
    .nv_wr_idx, .nv_wr_data, .sfr_wr, .sfr_idx, .sfr_wdata, .sfr_rdata, .rst_n_pin,
    .prog_clock_pin, .prog_data_in, .prog_data_out, .prog_data_oe_n, .brownout_low_pin,
    .boot_block_size, .boot_flash_kb, .application_flash_kb, .brownout_detect_on,
    .brownout_trip_level, .brownout_blocks_selfprog, .brownout_reset_req, .watchdog_mode,
    .cpu_hold, .prog_mode, .options_valid);
  cod_prog_model prog (.mclk, .nv_wr, .nv_wr_idx, .nv_wr_data, .nv_boot_byte, .nv_bod_byte,
    .nv_wdt_byte, .rst_n_pin, .prog_clock_pin, .prog_data_in, .prog_data_out, .prog_data_oe_n);

  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  // Ceiling well above the roughly 800 cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write lands on the copy next edge, on the outputs one edge later
  task automatic sfr_put(input logic [1:0] i, input logic [7:0] d);
    @(negedge mclk);
    sfr_wr = 1'b1;
    sfr_idx = i;
    sfr_wdata = d;
    @(negedge mclk);
    sfr_wr = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic sfr_get(input logic [1:0] i, output logic [7:0] d);
    @(negedge mclk);
    sfr_idx = i;
    @(negedge mclk);
    d = sfr_rdata;
  endtask
  // Bounded wait for run state, then one edge for the outputs
  task automatic wait_run();
    int n;
    n = 0;
    while (options_valid !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk("options_valid", 8'h01, {7'h0, options_valid});
    @(negedge mclk);
  endtask
  task automatic do_reset(input logic p);
    @(negedge mclk);
    rst = 1'b1;
    por = p;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    wait_run();
  endtask

  initial begin
    logic [7:0]       rd;
    logic [2:0]       kb;
    cod_wdt_mode_type m;
    do_reset(1'b1);
    // Erased bytes: no boot block, plain timer
    chk("boot_kb", 8'h00, {5'h0, boot_flash_kb});
    chk("app_kb", 8'h12, {3'h0, application_flash_kb});
    chk("wdt_mode", {6'h0, WDM_TIMER}, {6'h0, watchdog_mode});
    sfr_get(2'h0, rd);
    chk("boot_copy", 8'hFF, rd);
    sfr_get(2'h3, rd);
    chk("unmapped", 8'hFF, rd);
    // Every boot size code
    for (int c = 0; c < 8; c++) begin
      kb = (c == 7) ? 3'h0 : (c > 3) ? 3'(7 - c) : 3'h4;
      sfr_put(2'h0, 8'(c));
      chk("boot_kb", {5'h0, kb}, {5'h0, boot_flash_kb});
      chk("app_kb", 8'h12 - {5'h0, kb}, {3'h0, application_flash_kb});
      chk("boot_size", 8'(c), {5'h0, boot_block_size});
      sfr_get(2'h0, rd);
      chk("boot_copy", 8'hF8 | 8'(c), rd);
    end
    // Every trip level
    for (int v = 0; v < 4; v++) begin
      sfr_put(2'h1, 8'hC3 | 8'(v << 4));
      chk("bod_level", {6'h0, lv[v]}, {6'h0, brownout_trip_level});
    end
    // Supply low: enable, inhibit and reset bits in turn
    brownout_low_pin = 1'b1;
    for (int k = 0; k < 4; k++) begin
      sfr_put(2'h1, bt[k]);
      repeat (3) @(negedge mclk);
      chk("bod_on", {7'h0, bt[k][7]}, {7'h0, brownout_detect_on});
      chk("block", {7'h0, bt[k][7] & bt[k][3]}, {7'h0, brownout_blocks_selfprog});
      if (bt[k][7]) chk("bod_rst", {7'h0, bt[k][2]}, {7'h0, brownout_reset_req});
    end
    // Supply good again: nothing blocked, no reset
    brownout_low_pin = 1'b0;
    sfr_put(2'h1, 8'hCF);
    repeat (3) @(negedge mclk);
    chk("block", 8'h00, {7'h0, brownout_blocks_selfprog});
    chk("bod_rst", 8'h00, {7'h0, brownout_reset_req});
    // Every watchdog code
    for (int w = 0; w < 16; w++) begin
      m = (w == 15) ? WDM_TIMER : (w == 5) ? WDM_HALT : WDM_RUN;
      sfr_put(2'h2, 8'(w << 4) | 8'h0F);
      chk("wdt_mode", {6'h0, m}, {6'h0, watchdog_mode});
    end
    // Serial programming, reserved bits left at one
    por = 1'b0;
    prog.enter();
    chk("prog_mode", 8'h01, {7'h0, prog_mode});
    chk("cpu_hold", 8'h01, {7'h0, cpu_hold});
    prog.frame(8'h01, 8'hE3, rd);
    prog.frame(8'h02, 8'h5F, rd);
    prog.frame(8'h81, 8'h00, rd);
    chk("serial_read", 8'hE3, rd);
    chk("stored_wdt", 8'h5F, nv_wdt_byte);
    prog.leave();
    wait_run();
    chk("wdt_reload", {6'h0, WDM_HALT}, {6'h0, watchdog_mode});
    chk("bod_kept", {6'h0, LVL_4V4}, {6'h0, brownout_trip_level});
    do_reset(1'b0);
    chk("bod_kept", {6'h0, LVL_4V4}, {6'h0, brownout_trip_level});
    do_reset(1'b1);
    chk("bod_por", {6'h0, LVL_2V7}, {6'h0, brownout_trip_level});
    give_verdict();
  end
endmodule
